// file: shared/eadp_regs.svh
`ifndef EADP_REGS_SVH
`define EADP_REGS_SVH
`define EADP_DATA_W        8
`define EADP_INSN_W        14
`define EADP_PC_W          12
`define EADP_DMEM_DEPTH    176
`define EADP_DADDR_W       8
`define EADP_PHASES        4
`define EADP_STATUS_ADDR   8'h03
`define EADP_PCL_ADDR      8'h02
`define EADP_IND_ADDR      8'h00
`define EADP_FSR_ADDR      8'h04
`define EADP_STAT_C        0
`define EADP_STAT_DC       1
`define EADP_STAT_Z        2
`define EADP_STATUS_RST    8'h18
`define EADP_NOP_INSN      14'h0000
`endif

// file: shared/eadp_pkg.sv
package eadp_pkg;
  typedef enum logic [1:0] {EADP_PH1, EADP_PH2, EADP_PH3, EADP_PH4} eadp_phase_e;
  typedef enum logic [3:0] {
    EADP_OP_NONE, EADP_OP_ADD, EADP_OP_SUB, EADP_OP_AND, EADP_OP_IOR, EADP_OP_XOR,
    EADP_OP_COM, EADP_OP_INC, EADP_OP_DEC, EADP_OP_RL, EADP_OP_RR, EADP_OP_SWAP,
    EADP_OP_PASS, EADP_OP_CLR
  } eadp_op_e;
endpackage

// file: hdl/eadp_alu.sv
`timescale 1ns/1ps
`include "eadp_regs.svh"
// Eight bit arithmetic unit with carry, nibble carry and zero
module eadp_alu #(
  parameter int WIDTH = `EADP_DATA_W
) (
  input  wire logic             [3:0] op,
  input  wire logic       [WIDTH-1:0] a_in,
  input  wire logic       [WIDTH-1:0] b_in,
  input  wire logic                   carry_in,
  output logic            [WIDTH-1:0] result,
  output logic                        carry_out,
  output logic                        nibble_carry_out,
  output logic                        zero_out
);
  initial if (WIDTH != 8) $error("eadp_alu supports only 8 bits");
  logic [WIDTH:0] sum;
  logic [4:0]     low;
  // Operation select, b is the accumulator side
  always_comb begin
    sum              = '0;
    low              = '0;
    result           = a_in;
    carry_out        = carry_in;
    nibble_carry_out = 1'b0;
    case (eadp_pkg::eadp_op_e'(op))
      eadp_pkg::EADP_OP_ADD: begin
        sum = {1'b0, a_in} + {1'b0, b_in};
        low = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]};
        result = sum[WIDTH-1:0];
        carry_out = sum[WIDTH];
        nibble_carry_out = low[4];
      end
      eadp_pkg::EADP_OP_SUB: begin
        // a - b as a + ~b + 1: carry high means no borrow
        sum = {1'b0, a_in} + {1'b0, ~b_in} + 9'h001;
        low = {1'b0, a_in[3:0]} + {1'b0, ~b_in[3:0]} + 5'h01;
        result = sum[WIDTH-1:0];
        carry_out = sum[WIDTH];
        nibble_carry_out = low[4];
      end
      eadp_pkg::EADP_OP_AND:  result = a_in & b_in;
      eadp_pkg::EADP_OP_IOR:  result = a_in | b_in;
      eadp_pkg::EADP_OP_XOR:  result = a_in ^ b_in;
      eadp_pkg::EADP_OP_COM:  result = ~a_in;
      eadp_pkg::EADP_OP_INC:  result = a_in + 8'h01;
      eadp_pkg::EADP_OP_DEC:  result = a_in - 8'h01;
      eadp_pkg::EADP_OP_RL: begin
        result = {a_in[WIDTH-2:0], carry_in};
        carry_out = a_in[WIDTH-1];
      end
      eadp_pkg::EADP_OP_RR: begin
        result = {carry_in, a_in[WIDTH-1:1]};
        carry_out = a_in[0];
      end
      eadp_pkg::EADP_OP_SWAP: result = {a_in[3:0], a_in[7:4]};
      eadp_pkg::EADP_OP_PASS: result = b_in;
      eadp_pkg::EADP_OP_CLR:  result = '0;
      default:                result = a_in;
    endcase
    zero_out = (result == '0);
  end
endmodule // eadp_alu

// file: hdl/eadp_dmem.sv
`timescale 1ns/1ps
`include "eadp_regs.svh"
// General purpose file memory, registered read
module eadp_dmem #(
  parameter int DEPTH  = `EADP_DMEM_DEPTH,
  parameter int ADDR_W = `EADP_DADDR_W
) (
  input  wire logic              clock,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic            [7:0]  rd_data,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic       [7:0]  wr_data
);
  initial if (DEPTH > (1 << ADDR_W)) $error("eadp_dmem depth exceeds address range");
  logic [7:0] mem [DEPTH];
  // Write and registered read
  always_ff @(posedge clock) begin
    if (wr_en && (int'(wr_addr) < DEPTH)) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= (int'(rd_addr) < DEPTH) ? mem[rd_addr] : 8'h00;
  end
endmodule // eadp_dmem

// file: hdl/eadp_core.sv
`timescale 1ns/1ps
`include "eadp_regs.svh"
// Function
// - Eight bit unit does add, subtract, shift and logic operations.
// - Arithmetic is two's complement.
// - Two-operand ops use accumulator and a file register or literal.
// - Single-operand ops use the accumulator or one file register.
// - Accumulator is eight bits and has no data memory address.
// - Carry, nibble carry and zero flags update per instruction.
// - Subtraction carry and nibble carry report inverted borrows: high means no borrow.
// - Fourteen bit instruction bus, one word per cycle, separate data bus.
// - Next instruction is fetched while current one executes.
// - All but branches take one instruction cycle; branches flush.
// - Addresses 4K program words and 176 data bytes.
// - Special registers including program counter mapped, direct and indirect.
// - Clock output at one quarter of the input rate.
// - Master clear low holds the device in reset.
// - Input clock divided into four phases per instruction cycle.
// - Operand read in phase two, destination write in phase four.
module eadp_core #(
  parameter int PC_W   = `EADP_PC_W,
  parameter int DEPTH  = `EADP_DMEM_DEPTH
) (
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic              master_clear_input,
  output logic      [PC_W-1:0]   prog_addr,
  input  wire logic       [13:0] prog_data,
  output logic                   instruction_rate_clock_out,
  output logic                   clock_phase_one,
  output logic                   clock_phase_two,
  output logic                   clock_phase_four,
  output logic             [7:0] accum_out,
  output logic             [7:0] status_out
);
  initial if (PC_W != 12 || DEPTH != 176) $error("eadp_core: unsupported size");

  // Master clear passes three flops, change taken when last two agree
  logic [2:0] master_clear_input_sync_reg;
  logic       master_clear_input_reg;
  logic       master_clear_input_next;
  always_comb begin
    master_clear_input_next = master_clear_input_reg;
    if (master_clear_input_sync_reg[1] == master_clear_input_sync_reg[2]) master_clear_input_next = master_clear_input_sync_reg[2];
  end
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      master_clear_input_sync_reg <= 3'h0;
      master_clear_input_reg      <= 1'b0;
    end else begin
      master_clear_input_sync_reg <= {master_clear_input_sync_reg[1:0], master_clear_input};
      master_clear_input_reg      <= master_clear_input_next;
    end
  end
  logic run;
  assign run = reset_n && master_clear_input_reg;

  // Phase generator
  eadp_pkg::eadp_phase_e phase_reg, phase_next;
  logic                  instruction_rate_clock_out_reg, instruction_rate_clock_out_next;
  always_comb begin
    phase_next  = run ? eadp_pkg::eadp_phase_e'(phase_reg + 2'h1) : eadp_pkg::EADP_PH1;
    instruction_rate_clock_out_next = run && (phase_next == eadp_pkg::EADP_PH3 || phase_next == eadp_pkg::EADP_PH4);
  end
  always_ff @(posedge clock) begin
    phase_reg  <= phase_next;
    instruction_rate_clock_out_reg <= instruction_rate_clock_out_next;
  end
  assign instruction_rate_clock_out = instruction_rate_clock_out_reg;
  assign clock_phase_one  = run && phase_reg == eadp_pkg::EADP_PH1;
  assign clock_phase_two  = run && phase_reg == eadp_pkg::EADP_PH2;
  assign clock_phase_four = run && phase_reg == eadp_pkg::EADP_PH4;

  // Decode helpers
  function automatic logic [7:0] file_addr(input logic [13:0] ins, input logic [7:0] fsr);
    file_addr = (ins[6:0] == 7'h00) ? fsr : {1'b0, ins[6:0]};
  endfunction
  function automatic logic [3:0] byte_op(input logic [3:0] f);
    case (f)
      4'h7:    byte_op = eadp_pkg::EADP_OP_ADD;
      4'h2:    byte_op = eadp_pkg::EADP_OP_SUB;
      4'h5:    byte_op = eadp_pkg::EADP_OP_AND;
      4'h4:    byte_op = eadp_pkg::EADP_OP_IOR;
      4'h6:    byte_op = eadp_pkg::EADP_OP_XOR;
      4'h9:    byte_op = eadp_pkg::EADP_OP_COM;
      4'hA:    byte_op = eadp_pkg::EADP_OP_INC;
      4'h3:    byte_op = eadp_pkg::EADP_OP_DEC;
      4'hD:    byte_op = eadp_pkg::EADP_OP_RL;
      4'hC:    byte_op = eadp_pkg::EADP_OP_RR;
      4'hE:    byte_op = eadp_pkg::EADP_OP_SWAP;
      4'h8:    byte_op = eadp_pkg::EADP_OP_NONE;
      4'h1:    byte_op = eadp_pkg::EADP_OP_CLR;
      default: byte_op = eadp_pkg::EADP_OP_NONE;
    endcase
  endfunction

  // Datapath state
  logic [PC_W-1:0] pc_reg, pc_next;
  logic     [13:0] ir_reg, ir_next;
  logic     [13:0] fetch_reg, fetch_next;
  logic            flush_reg, flush_next;
  logic      [7:0] w_reg, w_next;
  logic      [7:0] status_reg, status_next;
  logic      [7:0] fsr_reg, fsr_next;
  logic      [7:0] opnd_reg, opnd_next;

  logic [7:0] daddr;
  logic [7:0] mem_rd;
  logic       mem_we;
  logic [7:0] alu_a, alu_b, alu_y;
  logic [3:0] alu_op;
  logic       alu_c, alu_dc, alu_z;
  logic       is_byte, is_lit, to_file, branch;
  logic       fc, fdc, fz;
  logic [7:0] sfr_rd;

  assign daddr = file_addr(ir_reg, fsr_reg);

  // Special register read view
  always_comb begin
    case (daddr)
      `EADP_STATUS_ADDR: sfr_rd = status_reg;
      `EADP_PCL_ADDR:    sfr_rd = pc_reg[7:0];
      `EADP_FSR_ADDR:    sfr_rd = fsr_reg;
      default:           sfr_rd = mem_rd;
    endcase
  end

  // Instruction decode and operand steering
  always_comb begin
    is_byte = ir_reg[13:12] == 2'b00;
    is_lit  = ir_reg[13:12] == 2'b11;
    to_file = is_byte && ir_reg[7];
    branch  = ir_reg[13:12] == 2'b10;
    alu_op  = eadp_pkg::EADP_OP_NONE;
    alu_a   = opnd_reg;
    alu_b   = w_reg;
    fc = 1'b0;
    fdc = 1'b0;
    fz = 1'b0;
    if (is_byte) begin
      alu_op = byte_op(ir_reg[11:8]);
      if (ir_reg[11:8] == 4'h0 && ir_reg[7]) alu_op = eadp_pkg::EADP_OP_PASS;
      if (ir_reg[11:8] == 4'h1 && !ir_reg[7]) alu_a = w_reg;
      fc  = alu_op inside {eadp_pkg::EADP_OP_ADD, eadp_pkg::EADP_OP_SUB,
                           eadp_pkg::EADP_OP_RL, eadp_pkg::EADP_OP_RR};
      fdc = alu_op inside {eadp_pkg::EADP_OP_ADD, eadp_pkg::EADP_OP_SUB};
      fz  = !(alu_op inside {eadp_pkg::EADP_OP_RL, eadp_pkg::EADP_OP_RR,
                             eadp_pkg::EADP_OP_SWAP, eadp_pkg::EADP_OP_NONE,
                             eadp_pkg::EADP_OP_PASS});
      if (ir_reg[11:8] == 4'h8) begin
        alu_op = eadp_pkg::EADP_OP_NONE;
        fz = 1'b1;
      end
    end else if (is_lit) begin
      alu_a = ir_reg[7:0];
      case (ir_reg[11:8])
        4'hE, 4'hF: alu_op = eadp_pkg::EADP_OP_ADD;
        4'hC, 4'hD: alu_op = eadp_pkg::EADP_OP_SUB;
        4'h9:       alu_op = eadp_pkg::EADP_OP_AND;
        4'h8:       alu_op = eadp_pkg::EADP_OP_IOR;
        4'hA:       alu_op = eadp_pkg::EADP_OP_XOR;
        default:    alu_op = eadp_pkg::EADP_OP_NONE;
      endcase
      fc  = alu_op inside {eadp_pkg::EADP_OP_ADD, eadp_pkg::EADP_OP_SUB};
      fdc = fc;
      fz  = alu_op != eadp_pkg::EADP_OP_NONE;
      if (alu_op == eadp_pkg::EADP_OP_NONE) begin
        alu_op = eadp_pkg::EADP_OP_NONE;
      end
    end
  end

  eadp_alu #(
    .WIDTH            (8)
  ) u_alu (
    .op               (alu_op),
    .a_in             (alu_a),
    .b_in             (alu_b),
    .carry_in         (status_reg[`EADP_STAT_C]),
    .result           (alu_y),
    .carry_out        (alu_c),
    .nibble_carry_out (alu_dc),
    .zero_out         (alu_z)
  );

  assign mem_we = run && phase_reg == eadp_pkg::EADP_PH4 && !flush_reg && to_file
                  && daddr != `EADP_STATUS_ADDR && daddr != `EADP_FSR_ADDR
                  && daddr != `EADP_PCL_ADDR;

  eadp_dmem #(
    .DEPTH   (DEPTH),
    .ADDR_W  (8)
  ) u_dmem (
    .clock   (clock),
    .rd_addr (daddr),
    .rd_data (mem_rd),
    .wr_en   (mem_we),
    .wr_addr (daddr),
    .wr_data (alu_y)
  );

  // Pipeline and execute next state
  always_comb begin
    pc_next     = pc_reg;
    ir_next     = ir_reg;
    fetch_next  = fetch_reg;
    flush_next  = flush_reg;
    w_next      = w_reg;
    status_next = status_reg;
    fsr_next    = fsr_reg;
    opnd_next   = opnd_reg;
    if (run) begin
      case (phase_reg)
        eadp_pkg::EADP_PH1: begin
          ir_next = fetch_reg;
          flush_next = 1'b0;
        end
        // Memory read launched in phase two lands here; fetch from the standing address
        eadp_pkg::EADP_PH3: begin
          opnd_next  = sfr_rd;
          fetch_next = prog_data;
        end
        eadp_pkg::EADP_PH4: begin
          pc_next = pc_reg + 12'h001;
          if (!flush_reg) begin
            if (alu_op != eadp_pkg::EADP_OP_NONE || (is_byte && ir_reg[11:8] == 4'h8)) begin
              if (to_file) begin
                if (daddr == `EADP_FSR_ADDR) fsr_next = alu_y;
                if (daddr == `EADP_STATUS_ADDR) status_next = alu_y;
              end else begin
                w_next = alu_y;
              end
            end
            if (is_lit && ir_reg[11:10] == 2'b00) w_next = ir_reg[7:0];
            if (fc)  status_next[`EADP_STAT_C]  = alu_c;
            if (fdc) status_next[`EADP_STAT_DC] = alu_dc;
            if (fz)  status_next[`EADP_STAT_Z]  = alu_z;
            if (branch) begin
              pc_next = {status_reg[5], ir_reg[10:0]};
              flush_next = 1'b1;
              fetch_next = `EADP_NOP_INSN;
            end
          end
        end
        default: ;
      endcase
    end
  end

  // Pipeline registers
  always_ff @(posedge clock) begin
    if (!run) begin
      pc_reg     <= '0;
      ir_reg     <= `EADP_NOP_INSN;
      fetch_reg  <= `EADP_NOP_INSN;
      flush_reg  <= 1'b1;
      w_reg      <= 8'h00;
      status_reg <= `EADP_STATUS_RST;
      fsr_reg    <= 8'h00;
      opnd_reg   <= 8'h00;
    end else begin
      pc_reg     <= pc_next;
      ir_reg     <= ir_next;
      fetch_reg  <= fetch_next;
      flush_reg  <= flush_next;
      w_reg      <= w_next;
      status_reg <= status_next;
      fsr_reg    <= fsr_next;
      opnd_reg   <= opnd_next;
    end
  end

  assign prog_addr  = pc_reg;
  assign accum_out  = w_reg;
  assign status_out = status_reg;
endmodule // eadp_core

// file: tb/eadp_prog_mem.sv
`timescale 1ns/1ps
// Program store on the far side of the fetch bus
module eadp_prog_mem #(
  parameter int PC_W = 12
) (
  input  wire logic [PC_W-1:0] prog_addr,
  output logic          [13:0] prog_data
);
  logic [13:0] mem [0:(1<<PC_W)-1];

  // One whole word per address, held while the address stands
  assign prog_data = mem[prog_addr];
endmodule // eadp_prog_mem

// file: tb/eadp_core_assertions.sv
`timescale 1ns/1ps
// Port-level timing checks of the core
module eadp_core_checker #(
  parameter int PC_W  = 12,
  parameter int DEPTH = 176
) (
  input wire logic            clock,
  input wire logic            reset_n,
  input wire logic            master_clear_input,
  input wire logic [PC_W-1:0] prog_addr,
  input wire logic     [13:0] prog_data,
  input wire logic            instruction_rate_clock_out,
  input wire logic            clock_phase_one,
  input wire logic            clock_phase_two,
  input wire logic            clock_phase_four,
  input wire logic      [7:0] accum_out,
  input wire logic      [7:0] status_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n || !master_clear_input);

  // Phase strobes and instruction rate output
  a_phase_period: assert property (clock_phase_one |-> ##4 clock_phase_one)
    else $error("phase one period wrong");
  a_phase_two_next: assert property (clock_phase_one |=> clock_phase_two)
    else $error("phase two missing");
  a_phase_four_place: assert property (clock_phase_two |-> ##2 clock_phase_four)
    else $error("phase four misplaced");
  a_strobe_onehot: assert property ($onehot0({clock_phase_one, clock_phase_two, clock_phase_four}))
    else $error("phase strobes overlap");
  a_instruction_rate_clock_out_shape: assert property (clock_phase_one |-> !instruction_rate_clock_out ##1
    !instruction_rate_clock_out ##1 instruction_rate_clock_out[*2])
    else $error("clock output shape wrong");
  // Fetch address and results
  a_pc_stands: assert property ($changed(prog_addr) |=> $stable(prog_addr)[*3])
    else $error("program address not held");
  a_acc_on_ph4: assert property ($changed(accum_out) |-> $past(clock_phase_four))
    else $error("accumulator changed off phase four");
  a_status_on_ph4: assert property ($changed(status_out) |-> $past(clock_phase_four))
    else $error("status changed off phase four");
  a_reset_values: assert property ($rose(reset_n) |-> status_out == 8'h18 && accum_out == 8'h00)
    else $error("reset values wrong");
endmodule // eadp_core_checker

bind eadp_core eadp_core_checker #(.PC_W(PC_W), .DEPTH(DEPTH)) i_eadp_core_checker (
  .clock                      (clock),
  .reset_n                    (reset_n),
  .master_clear_input         (master_clear_input),
  .prog_addr                  (prog_addr),
  .prog_data                  (prog_data),
  .instruction_rate_clock_out (instruction_rate_clock_out),
  .clock_phase_one            (clock_phase_one),
  .clock_phase_two            (clock_phase_two),
  .clock_phase_four           (clock_phase_four),
  .accum_out                  (accum_out),
  .status_out                 (status_out)
);

// file: tb/tb_eadp_core.sv
`timescale 1ns/1ps
module tb_eadp_core;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        master_clear_input = 1'b1;
  logic [11:0] prog_addr;
  logic [13:0] prog_data;
  logic        clk_out;
  logic        ph1;
  logic        ph2;
  logic        ph4;
  logic  [7:0] accum_out;
  logic  [7:0] status_out;
  int          n_errors = 0;
  int          cmp_count = 0;

  // Clock at 25 MHz
  always #20 clock = ~clock;

  // Core and its program store
  eadp_core i_eadp_core (.clock(clock), .reset_n(reset_n), .master_clear_input(master_clear_input),
    .prog_addr(prog_addr), .prog_data(prog_data), .instruction_rate_clock_out(clk_out),
    .clock_phase_one(ph1), .clock_phase_two(ph2), .clock_phase_four(ph4),
    .accum_out(accum_out), .status_out(status_out));
  eadp_prog_mem i_eadp_prog_mem (.prog_addr(prog_addr), .prog_data(prog_data));

  // Counts and verdict
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Byte compare
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Bounded wait for the first phase strobe
  task automatic wait_ph1();
    int k;
    k = 0;
    while (ph1 !== 1'b1) begin
      @(posedge clock);
      k++;
      if (k > 20) begin
        n_errors++;
        $display("[FAIL] %0t no phase strobe", $time);
        tally_and_finish();
      end
    end
  endtask

  // Load program, reset, run it, compare accumulator and flags
  task automatic exec(input logic [13:0] p [$], input logic [7:0] w, input logic [2:0] f);
    for (int i = 0; i < 4096; i++) begin
      i_eadp_prog_mem.mem[i] = (i < p.size()) ? p[i] : 14'h0000;
    end
    reset_n <= 1'b0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    wait_ph1();
    repeat ((p.size() + 3) * 4) @(posedge clock);
    check8(accum_out, w, "accumulator");
    check8({5'h00, status_out[2:0]}, {5'h00, f}, "flags");
  endtask

  // Reset values while held
  task automatic t_reset();
    reset_n <= 1'b0;
    repeat (12) @(posedge clock);
    check8(accum_out, 8'h00, "reset accumulator");
    check8(status_out, 8'h18, "reset status");
    check8({7'h00, clk_out}, 8'h00, "reset clock output");
  endtask

  // Addition, nibble carry and wrap to zero
  task automatic t_add();
    exec('{14'h300F, 14'h3E01}, 8'h10, 3'b010);
    exec('{14'h30FF, 14'h3E01}, 8'h00, 3'b111);
  endtask

  // Subtraction with and without borrow
  task automatic t_sub();
    exec('{14'h3001, 14'h3C00}, 8'hFF, 3'b000);
    exec('{14'h3001, 14'h3C05}, 8'h04, 3'b011);
  endtask

  // Logic ops, zero result
  task automatic t_logic();
    exec('{14'h30F0, 14'h393C, 14'h3811, 14'h3A31}, 8'h00, 3'b100);
  endtask

  // File operands, single operand op and rotate
  task automatic t_file();
    exec('{14'h3030, 14'h00A0, 14'h3005, 14'h0720, 14'h00A1, 14'h0A20, 14'h0721},
         8'h66, 3'b000);
    exec('{14'h3081, 14'h00A0, 14'h0D20}, 8'h02, 3'b001);
  endtask

  // Indirect store through the pointer register, then indirect load clears zero
  task automatic t_indirect();
    exec('{14'h3020, 14'h0084, 14'h305A, 14'h0080, 14'h0100, 14'h0800},
         8'h5A, 3'b000);
  endtask

  // Branch flushes the word behind it
  task automatic t_branch();
    exec('{14'h3011, 14'h2804, 14'h3E01, 14'h3E02, 14'h3E10}, 8'h21, 3'b000);
  endtask

  // Master clear mid-run, then restart
  task automatic t_master_clear_input();
    exec('{14'h300F, 14'h3E01}, 8'h10, 3'b010);
    master_clear_input <= 1'b0;
    repeat (8) @(posedge clock);
    check8(accum_out, 8'h00, "clear accumulator");
    check8(status_out, 8'h18, "clear status");
    master_clear_input <= 1'b1;
    wait_ph1();
    repeat (20) @(posedge clock);
    check8(accum_out, 8'h10, "rerun accumulator");
  endtask

  // Main sequence
  initial begin
    t_reset();
    t_add();
    t_sub();
    t_logic();
    t_file();
    t_indirect();
    t_branch();
    t_master_clear_input();
    tally_and_finish();
  end
endmodule // tb_eadp_core
